// ===== dv/omc_host.sv
// debug host model: reset strap level and command strobes
`timescale 1ns/1ps
module omc_host
(
	// clock
	input wire logic clk,
	// debug side
	output logic debug_pin,
	output logic cmd_valid,
	output logic [2:0] cmd_code
);
	initial
	begin
		debug_pin = 1'b1;
		cmd_valid = 1'b0;
		cmd_code = 3'h7;
	end
	// one strobe; code is scrambled once the strobe drops so stale values never match
	task send(input logic [2:0] c);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
	endtask
	task strap(input logic lvl);
		debug_pin = lvl;
	endtask
endmodule

// ===== dv/operating_mode_controller_test.sv
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
module operating_mode_controller_test
	import omc_pkg::*;
;
	logic CLK = 1'b0, NRST = 1'b0, POR_FLAG = 1'b1, IRQ_ASYNC = 1'b0;
	logic WAIT_EXEC = 1'b0, STOP_EXEC = 1'b0, BACKGROUND_INSTRUCTION_EXEC = 1'b0, BDC_BREAK = 1'b0;
	logic DBG_BREAK = 1'b0, IRQ_REQ = 1'b0, PPD_ACK = 1'b0, STOP_PERMIT = 1'b1;
	logic [2:0] STOP_SEL = 3'h4;
	logic LVD_STOP_EN = 1'b0, DEBUG_ENTRY_EN = 1'b0;
	logic DEBUG_PIN, CMD_VALID, CMD_ACCEPT, CMD_REJECT, CMD_ERR, CPU_CLK_EN, CPU_SUSPEND;
	logic [2:0] CMD_CODE, MODE;
	logic [15:0] FETCH_ADDR;
	logic FETCH_START, TRACE_STEP, CLR_IMASK, IRQ_STACK, VEC_IRQ, ILLEGAL_RST, SYS_CLK_EN;
	logic LFO_EN, RAM_PWR, CIRC_PWR, REG_FULL, PIN_LATCH, PPD_FLAG;
	int miscompares = 0;
	int n_tests = 0;

	always #20 CLK = ~CLK;

	omc_host i_host (.clk(CLK), .debug_pin(DEBUG_PIN), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE));

	omc_top i_dut (.CLK(CLK), .NRST(NRST), .DEBUG_PIN(DEBUG_PIN), .POR_FLAG(POR_FLAG),
		.WAIT_EXEC(WAIT_EXEC), .STOP_EXEC(STOP_EXEC), .BACKGROUND_INSTRUCTION_EXEC(BACKGROUND_INSTRUCTION_EXEC),
		.BDC_BREAK(BDC_BREAK), .DBG_BREAK(DBG_BREAK), .IRQ_REQ(IRQ_REQ), .IRQ_ASYNC(IRQ_ASYNC),
		.CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ACCEPT(CMD_ACCEPT),
		.CMD_REJECT(CMD_REJECT), .CMD_ERR(CMD_ERR), .STOP_PERMIT(STOP_PERMIT),
		.STOP_SEL(STOP_SEL), .LVD_STOP_EN(LVD_STOP_EN), .DEBUG_ENTRY_EN(DEBUG_ENTRY_EN),
		.PPD_ACK(PPD_ACK), .MODE(MODE), .CPU_CLK_EN(CPU_CLK_EN), .CPU_SUSPEND(CPU_SUSPEND),
		.FETCH_START(FETCH_START), .FETCH_ADDR(FETCH_ADDR), .TRACE_STEP(TRACE_STEP),
		.CLR_IMASK(CLR_IMASK), .IRQ_STACK(IRQ_STACK), .VEC_IRQ(VEC_IRQ),
		.ILLEGAL_RST(ILLEGAL_RST), .SYS_CLK_EN(SYS_CLK_EN), .LFO_EN(LFO_EN),
		.RAM_PWR(RAM_PWR), .CIRC_PWR(CIRC_PWR), .REG_FULL(REG_FULL),
		.PIN_LATCH(PIN_LATCH), .PPD_FLAG(PPD_FLAG));

	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	// one-cycle event pulse; returns at the falling edge where the answer is visible
	task fire(input int k);
		@(negedge CLK);
		{WAIT_EXEC, STOP_EXEC, BACKGROUND_INSTRUCTION_EXEC, BDC_BREAK, DBG_BREAK, IRQ_REQ, PPD_ACK} = 7'h40 >> k;
		@(negedge CLK);
		{WAIT_EXEC, STOP_EXEC, BACKGROUND_INSTRUCTION_EXEC, BDC_BREAK, DBG_BREAK, IRQ_REQ, PPD_ACK} = 7'h00;
	endtask

	task do_reset(input logic pin, input logic por);
		NRST = 1'b0;
		POR_FLAG = por;
		i_host.strap(pin);
		repeat (5) @(negedge CLK);
		chk(MODE === 3'h0 && FETCH_ADDR === 16'h0000 && PPD_FLAG === 1'b0, "reset state");
		NRST = 1'b1;
		@(negedge CLK);
		i_host.strap(1'b1);
	endtask

	task t_run_cmds;
		for (int c = 0; c < 7; c++)
		begin
			if (c != 3)
			begin
				i_host.send(c[2:0]);
				chk(CMD_ACCEPT === (c < 3) && CMD_REJECT === (c > 3), "run command");
			end
		end
		i_host.send(CMD_BACKGROUND);
		chk(CMD_ACCEPT === 1'b1 && MODE === 3'h2, "background command");
	endtask

	task t_debug_pin;
		chk(CPU_SUSPEND === 1'b1 && CPU_CLK_EN === 1'b0, "cpu not suspended");
		fire(0);
		chk(MODE === 3'h2, "wait taken in background");
		for (int c = 0; c < 6; c++)
		begin
			i_host.send(c[2:0]);
			chk(CMD_ACCEPT === 1'b1 && TRACE_STEP === (c == 5) && MODE === 3'h2, "debug_pin cmd");
		end
		i_host.send(CMD_GO);
		chk(CMD_ACCEPT === 1'b1 && MODE === 3'h1 && CPU_CLK_EN === 1'b1, "resume");
	endtask

	task t_breaks;
		for (int k = 2; k < 5; k++)
		begin
			fire(k);
			chk(MODE === 3'h2, "break entry");
			i_host.send(CMD_GO);
		end
	endtask

	task t_wait;
		fire(0);
		chk(MODE === 3'h3 && CLR_IMASK === 1'b1 && CPU_CLK_EN === 1'b0, "wait entry");
		chk(SYS_CLK_EN === 1'b1 && REG_FULL === 1'b1, "wait clocks");
		for (int c = 0; c < 7; c++)
		begin
			if (c != 3)
			begin
				i_host.send(c[2:0]);
				chk(CMD_ERR === (c == 1) && CMD_REJECT === (c != 1) && MODE === 3'h3, "wait cmd");
			end
		end
		fire(5);
		chk(MODE === 3'h1 && IRQ_STACK === 1'b1 && VEC_IRQ === 1'b1, "wait wake");
		fire(0);
		i_host.send(CMD_BACKGROUND);
		chk(CMD_ACCEPT === 1'b1 && MODE === 3'h2, "wait to background");
		i_host.send(CMD_GO);
	endtask

	task t_stop(input logic [2:0] sel, input logic lvd, input logic dbg, input logic [2:0] m);
		STOP_SEL = sel;
		LVD_STOP_EN = lvd;
		DEBUG_ENTRY_EN = dbg;
		// alternate the wake source so the non-async vector path is seen in stop4
		IRQ_ASYNC = sel[0];
		fire(1);
		chk(MODE === m && CPU_CLK_EN === 1'b0 && LFO_EN === 1'b1, "stop entry");
		chk(SYS_CLK_EN === dbg && RAM_PWR === (m != 3'h4), "stop clock");
		chk(CIRC_PWR === (m > 3'h5) && REG_FULL === (m == 3'h7), "stop power");
		chk(PIN_LATCH === (m == 3'h5), "pins not latched in stop");
		i_host.send(CMD_MEM_STAT);
		chk(CMD_ERR === 1'b1 && CMD_ACCEPT === 1'b0, "stop status");
		i_host.send(CMD_BACKGROUND);
		chk(CMD_REJECT === 1'b1 && MODE === m, "stop background");
		fire(5);
		chk(MODE === 3'h1 && PPD_FLAG === (m == 3'h5), "stop wake");
		if (m < 3'h6)
			chk(FETCH_START === 1'b1 && FETCH_ADDR === RUN_START_ADDR, "reset path");
		else
			chk(IRQ_STACK === 1'b1 && VEC_IRQ === IRQ_ASYNC, "irq vector");
		if (m == 3'h5)
		begin
			chk(PIN_LATCH === 1'b1, "pins released early");
			fire(6);
			chk(PPD_FLAG === 1'b0 && PIN_LATCH === 1'b0, "ack");
		end
	endtask

	task t_illegal;
		STOP_PERMIT = 1'b0;
		fire(1);
		chk(ILLEGAL_RST === 1'b1 && MODE === 3'h0, "illegal stop");
		@(negedge CLK);
		chk(MODE === 3'h1, "restart");
		STOP_PERMIT = 1'b1;
	endtask

	initial
	begin
		// the scenarios need about 160 cycles; 1000 leaves ample margin
		#40000;
		miscompares++;
		print_verdict;
	end

	initial
	begin
		do_reset(1'b1, 1'b1);
		chk(MODE === 3'h1 && FETCH_START === 1'b1 && FETCH_ADDR === RUN_START_ADDR, "strap run");
		t_run_cmds;
		t_debug_pin;
		t_breaks;
		t_wait;
		for (int s = 0; s < 8; s++)
			t_stop(s[2:0], 1'b0, 1'b0, (s > 0 && s < 5) ? 3'(3 + s) : 3'h7);
		t_stop(SEL_STOP1, 1'b1, 1'b0, 3'h7);
		t_stop(SEL_STOP2, 1'b0, 1'b1, 3'h7);
		DEBUG_ENTRY_EN = 1'b0;
		t_illegal;
		do_reset(1'b0, 1'b1);
		chk(MODE === 3'h2 && CPU_SUSPEND === 1'b1, "strap background");
		print_verdict;
	end
endmodule

// ===== include/omc_pkg.sv
// constants and types shared by the operating mode controller
package omc_pkg;

	typedef enum logic [2:0] {
		OMC_RESET,
		OMC_RUN,
		OMC_DEBUG_PIN,
		OMC_WAIT,
		OMC_STOP1,
		OMC_STOP2,
		OMC_STOP3,
		OMC_STOP4
	} omc_state_t;

	// debug command classes presented on the command port
	localparam logic [2:0] CMD_MEM = 3'h0;
	localparam logic [2:0] CMD_MEM_STAT = 3'h1;
	localparam logic [2:0] CMD_BDC_REG = 3'h2;
	localparam logic [2:0] CMD_BACKGROUND = 3'h3;
	localparam logic [2:0] CMD_CPU_REG = 3'h4;
	localparam logic [2:0] CMD_TRACE = 3'h5;
	localparam logic [2:0] CMD_GO = 3'h6;

	// stop mode select codes; anything else means stop4
	localparam logic [2:0] SEL_STOP1 = 3'h1;
	localparam logic [2:0] SEL_STOP2 = 3'h2;
	localparam logic [2:0] SEL_STOP3 = 3'h3;
	localparam logic [2:0] SEL_STOP4 = 3'h4;

	localparam logic [15:0] RUN_START_ADDR = 16'hC000;
	localparam int LFO_FREQ_HZ = 1000;
	localparam logic [15:0] FETCH_ADDR_RST = 16'h0000;
	localparam logic PPD_FLAG_RST = 1'b0;

endpackage

// ===== rtl/omc_cmd_gate.sv
// debug command admission by operating mode
`timescale 1ns/1ps
module omc_cmd_gate
	import omc_pkg::*;
(
	// mode and command
	input omc_state_t st,
	input logic valid,
	input logic [2:0] cmd,
	// verdict
	output logic ok,
	output logic rej,
	output logic err
);

	logic nonintr;
	logic active_only;
	logic in_low_power;
	logic allow;

	assign nonintr = (cmd == CMD_MEM) || (cmd == CMD_MEM_STAT)
		|| (cmd == CMD_BDC_REG) || (cmd == CMD_BACKGROUND);
	assign active_only = (cmd == CMD_CPU_REG) || (cmd == CMD_TRACE) || (cmd == CMD_GO);
	assign in_low_power = (st == OMC_WAIT) || (st == OMC_STOP1) || (st == OMC_STOP2)
		|| (st == OMC_STOP3) || (st == OMC_STOP4);

	// stop modes refuse the background command: the pin cannot wake the core there
	assign allow = ((st == OMC_RUN) && nonintr) // RULE_06
		|| ((st == OMC_DEBUG_PIN) && (nonintr || active_only)) // RULE_07
		|| ((st == OMC_WAIT) && (cmd == CMD_BACKGROUND)); // RULE_11 RULE_04

	// status reads in wait or stop answer with an error and touch no memory
	assign err = valid && in_low_power && (cmd == CMD_MEM_STAT); // RULE_12
	assign ok = valid && allow;
	assign rej = valid && !allow && !err;

endmodule

// ===== rtl/omc_top.sv
// operating mode controller: run, background debug, wait and stop modes
// Summary of operation
// RULE_01: pin high at reset: run from C000
// RULE_02: pin low at power-up: background debug
// RULE_03: command, instruction or breakpoints enter background
// RULE_04: pin activation refused while in stop
// RULE_05: background mode suspends CPU, awaits commands
// RULE_06: non-intrusive commands work in run, background
// RULE_07: CPU, trace, resume only in background
// RULE_08: wait gates CPU clock, system stays
// RULE_09: wait entry clears interrupt mask bit
// RULE_10: interrupt wakes wait into stacking sequence
// RULE_11: wait accepts only background and status reads
// RULE_12: status reads in wait/stop return error
// RULE_13: background command wakes wait into background
// RULE_14: permitted stop enters selected stop mode
// RULE_15: forbidden stop forces illegal-opcode reset
// RULE_16: stop halts clocks except low oscillator
// RULE_17: stop1..4 power RAM, circuits, regulator differently
// RULE_18: low-volt-in-stop turns stop1/2 into stop4
// RULE_19: debug entry enable turns stop1/2 into stop4
// RULE_20: stop2 wake sets flag, latch until ack
// RULE_21: stop3 interrupt exit takes interrupt vector
// RULE_22: unsupported stop selection falls back to stop4
`timescale 1ns/1ps
module omc_top
	import omc_pkg::*;
(
	// clock and reset
	input logic CLK,
	input logic NRST,
	// reset strap
	input logic DEBUG_PIN,
	input logic POR_FLAG,
	// CPU events
	input logic WAIT_EXEC,
	input logic STOP_EXEC,
	input logic BACKGROUND_INSTRUCTION_EXEC,
	input logic BDC_BREAK,
	input logic DBG_BREAK,
	input logic IRQ_REQ,
	input logic IRQ_ASYNC,
	// debug command port
	input logic CMD_VALID,
	input logic [2:0] CMD_CODE,
	output logic CMD_ACCEPT,
	output logic CMD_REJECT,
	output logic CMD_ERR,
	// configuration
	input logic STOP_PERMIT,
	input logic [2:0] STOP_SEL,
	input logic LVD_STOP_EN,
	input logic DEBUG_ENTRY_EN,
	input logic PPD_ACK,
	// mode and CPU control
	output logic [2:0] MODE,
	output logic CPU_CLK_EN,
	output logic CPU_SUSPEND,
	output logic FETCH_START,
	output logic [15:0] FETCH_ADDR,
	output logic TRACE_STEP,
	output logic CLR_IMASK,
	output logic IRQ_STACK,
	output logic VEC_IRQ,
	output logic ILLEGAL_RST,
	// clocks and power
	output logic SYS_CLK_EN,
	output logic LFO_EN,
	output logic RAM_PWR,
	output logic CIRC_PWR,
	output logic REG_FULL,
	output logic PIN_LATCH,
	output logic PPD_FLAG
);

	omc_state_t state_r;
	omc_state_t state_nxt;
	logic cmd_ok;
	logic cmd_rej;
	logic cmd_err;
	logic bg_cmd;
	logic debug_pin_evt;
	logic in_stop;
	logic deep_req;
	logic [2:0] stop_eff;
	omc_state_t stop_target;
	logic bdc_clk_r;
	logic bdc_clk_nxt;
	logic ppd_r;
	logic ppd_nxt;
	logic fetch_start_nxt;
	logic [15:0] fetch_addr_nxt;
	logic clr_imask_nxt;
	logic irq_stack_nxt;
	logic vec_irq_nxt;
	logic illegal_nxt;
	logic trace_nxt;

	omc_cmd_gate u_gate (
		.st(state_r),
		.valid(CMD_VALID),
		.cmd(CMD_CODE),
		.ok(cmd_ok),
		.rej(cmd_rej),
		.err(cmd_err)
	);

	assign bg_cmd = cmd_ok && (CMD_CODE == CMD_BACKGROUND);
	assign debug_pin_evt = bg_cmd || BACKGROUND_INSTRUCTION_EXEC || BDC_BREAK || DBG_BREAK; // RULE_03
	assign in_stop = (state_r == OMC_STOP1) || (state_r == OMC_STOP2)
		|| (state_r == OMC_STOP3) || (state_r == OMC_STOP4);

	// stop1/2 would cut the regulator that the voltage monitor or debug logic needs
	assign deep_req = (STOP_SEL == SEL_STOP1) || (STOP_SEL == SEL_STOP2);
	assign stop_eff = (deep_req && (LVD_STOP_EN || DEBUG_ENTRY_EN)) ? SEL_STOP4 : STOP_SEL; // RULE_18 RULE_19
	assign stop_target = (stop_eff == SEL_STOP1) ? OMC_STOP1 :
		(stop_eff == SEL_STOP2) ? OMC_STOP2 :
		(stop_eff == SEL_STOP3) ? OMC_STOP3 : OMC_STOP4; // RULE_14 RULE_22

	always_comb
	begin
		state_nxt = state_r;
		fetch_start_nxt = 1'b0;
		fetch_addr_nxt = FETCH_ADDR;
		clr_imask_nxt = 1'b0;
		irq_stack_nxt = 1'b0;
		vec_irq_nxt = 1'b0;
		illegal_nxt = 1'b0;
		trace_nxt = 1'b0;
		bdc_clk_nxt = bdc_clk_r;
		case (state_r)
			OMC_RESET:
			begin
				// strap is taken on the first edge after reset release
				if (DEBUG_PIN || !POR_FLAG)
				begin
					state_nxt = OMC_RUN; // RULE_01
					fetch_start_nxt = 1'b1;
					fetch_addr_nxt = RUN_START_ADDR;
				end
				else
				begin
					state_nxt = OMC_DEBUG_PIN; // RULE_02
				end
			end
			OMC_RUN:
			begin
				if (debug_pin_evt)
				begin
					state_nxt = OMC_DEBUG_PIN; // RULE_03
				end
				else if (STOP_EXEC && STOP_PERMIT)
				begin
					state_nxt = stop_target; // RULE_14
					bdc_clk_nxt = DEBUG_ENTRY_EN; // RULE_19
				end
				else if (STOP_EXEC)
				begin
					state_nxt = OMC_RESET; // RULE_15
					illegal_nxt = 1'b1;
				end
				else if (WAIT_EXEC)
				begin
					state_nxt = OMC_WAIT; // RULE_08
					clr_imask_nxt = 1'b1; // RULE_09
				end
			end
			OMC_DEBUG_PIN:
			begin
				// CPU stays suspended; only commands move it
				if (cmd_ok && (CMD_CODE == CMD_GO))
				begin
					state_nxt = OMC_RUN; // RULE_05 RULE_07
				end
				else if (cmd_ok && (CMD_CODE == CMD_TRACE))
				begin
					trace_nxt = 1'b1; // RULE_07
				end
			end
			OMC_WAIT:
			begin
				if (bg_cmd)
				begin
					state_nxt = OMC_DEBUG_PIN; // RULE_13
				end
				else if (IRQ_REQ)
				begin
					state_nxt = OMC_RUN; // RULE_10
					irq_stack_nxt = 1'b1;
					vec_irq_nxt = 1'b1;
				end
			end
			OMC_STOP1, OMC_STOP2:
			begin
				// wake restarts as from power-on, through the reset vector
				if (IRQ_REQ)
				begin
					state_nxt = OMC_RUN;
					fetch_start_nxt = 1'b1;
					fetch_addr_nxt = RUN_START_ADDR;
					bdc_clk_nxt = 1'b0;
				end
			end
			OMC_STOP3, OMC_STOP4:
			begin
				if (IRQ_REQ)
				begin
					state_nxt = OMC_RUN;
					irq_stack_nxt = 1'b1;
					vec_irq_nxt = IRQ_ASYNC; // RULE_21
					bdc_clk_nxt = 1'b0;
				end
			end
			default:
			begin
				state_nxt = OMC_RESET;
			end
		endcase
	end

	// set wins over acknowledge so a fresh stop2 wake is never lost
	assign ppd_nxt = ((state_r == OMC_STOP2) && (state_nxt == OMC_RUN))
		|| (ppd_r && !PPD_ACK); // RULE_20

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_r <= OMC_RESET;
			bdc_clk_r <= 1'b0;
			ppd_r <= PPD_FLAG_RST;
			FETCH_START <= 1'b0;
			FETCH_ADDR <= FETCH_ADDR_RST;
			CLR_IMASK <= 1'b0;
			IRQ_STACK <= 1'b0;
			VEC_IRQ <= 1'b0;
			ILLEGAL_RST <= 1'b0;
			TRACE_STEP <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bdc_clk_r <= bdc_clk_nxt;
			ppd_r <= ppd_nxt;
			FETCH_START <= fetch_start_nxt;
			FETCH_ADDR <= fetch_addr_nxt;
			CLR_IMASK <= clr_imask_nxt;
			IRQ_STACK <= irq_stack_nxt;
			VEC_IRQ <= vec_irq_nxt;
			ILLEGAL_RST <= illegal_nxt;
			TRACE_STEP <= trace_nxt;
		end
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			CMD_ACCEPT <= 1'b0;
			CMD_REJECT <= 1'b0;
			CMD_ERR <= 1'b0;
		end
		else
		begin
			CMD_ACCEPT <= cmd_ok; // RULE_06 RULE_07
			CMD_REJECT <= cmd_rej; // RULE_11
			CMD_ERR <= cmd_err; // RULE_12
		end
	end

	assign MODE = 3'(state_r);
	assign CPU_CLK_EN = (state_r == OMC_RUN); // RULE_08
	assign CPU_SUSPEND = (state_r == OMC_DEBUG_PIN); // RULE_05
	assign SYS_CLK_EN = !in_stop || bdc_clk_r; // RULE_16 RULE_19
	assign LFO_EN = 1'b1; // RULE_16
	assign RAM_PWR = (state_r != OMC_STOP1); // RULE_17
	assign CIRC_PWR = (state_r != OMC_STOP1) && (state_r != OMC_STOP2); // RULE_17
	assign REG_FULL = !in_stop || (state_r == OMC_STOP4); // RULE_17
	assign PIN_LATCH = (state_r == OMC_STOP2) || ppd_r; // RULE_20
	assign PPD_FLAG = ppd_r;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	property p_strap_run;
		(state_r == OMC_RESET) && DEBUG_PIN |=> (state_r == OMC_RUN) && FETCH_START
			&& (FETCH_ADDR == RUN_START_ADDR);
	endproperty
	a_strap_run: assert property (p_strap_run) else $error("strap high did not start run"); // RULE_01

	property p_strap_debug_pin;
		(state_r == OMC_RESET) && !DEBUG_PIN && POR_FLAG |=> CPU_SUSPEND ##1 !FETCH_START;
	endproperty
	a_strap_debug_pin: assert property (p_strap_debug_pin) else $error("strap low missed background"); // RULE_02

	property p_debug_pin_entry;
		(state_r == OMC_RUN) && (BACKGROUND_INSTRUCTION_EXEC || DBG_BREAK || BDC_BREAK) |=> CPU_SUSPEND && !CPU_CLK_EN;
	endproperty
	a_debug_pin_entry: assert property (p_debug_pin_entry) else $error("break did not enter background"); // RULE_03

	property p_wait_entry;
		(state_r == OMC_RUN) && WAIT_EXEC && !debug_pin_evt && !STOP_EXEC |=> CLR_IMASK
			&& !CPU_CLK_EN && SYS_CLK_EN && REG_FULL;
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong"); // RULE_08

	property p_wait_irq;
		(state_r == OMC_WAIT) && IRQ_REQ && !bg_cmd |=> IRQ_STACK && CPU_CLK_EN;
	endproperty
	a_wait_irq: assert property (p_wait_irq) else $error("interrupt did not wake wait"); // RULE_10

	property p_wait_reject;
		(state_r == OMC_WAIT) && CMD_VALID && (CMD_CODE == CMD_MEM) |=> CMD_REJECT && !CMD_ACCEPT;
	endproperty
	a_wait_reject: assert property (p_wait_reject) else $error("wait took a memory command"); // RULE_11

	property p_stat_err;
		in_stop && CMD_VALID && (CMD_CODE == CMD_MEM_STAT) |=> CMD_ERR && !CMD_ACCEPT;
	endproperty
	a_stat_err: assert property (p_stat_err) else $error("status read in stop gave no error"); // RULE_12

	property p_illegal;
		(state_r == OMC_RUN) && STOP_EXEC && !STOP_PERMIT && !debug_pin_evt |=> ILLEGAL_RST
			&& !in_stop ##1 !ILLEGAL_RST;
	endproperty
	a_illegal: assert property (p_illegal) else $error("forbidden stop not reset"); // RULE_15

	property p_stop_lvd;
		(state_r == OMC_RUN) && STOP_EXEC && STOP_PERMIT && !debug_pin_evt && deep_req
			&& LVD_STOP_EN |=> (state_r == OMC_STOP4) && REG_FULL;
	endproperty
	a_stop_lvd: assert property (p_stop_lvd) else $error("deep stop kept with monitor on"); // RULE_18

	// clock choice is judged against the enable seen at entry, not the held copy
	property p_stop_clk;
		(state_r == OMC_RUN) && STOP_EXEC && STOP_PERMIT && !debug_pin_evt |=> in_stop && LFO_EN
			&& !CPU_CLK_EN && (SYS_CLK_EN == $past(DEBUG_ENTRY_EN));
	endproperty
	a_stop_clk: assert property (p_stop_clk) else $error("clocks wrong in stop"); // RULE_16

	property p_ppd;
		(state_r == OMC_STOP2) && IRQ_REQ |=> PPD_FLAG && PIN_LATCH;
	endproperty
	a_ppd: assert property (p_ppd) else $error("stop2 wake did not set flag"); // RULE_20

	property p_ppd_hold;
		PPD_FLAG && !PPD_ACK |=> PPD_FLAG;
	endproperty
	a_ppd_hold: assert property (p_ppd_hold) else $error("flag dropped without ack"); // RULE_20

	property p_stop3_vec;
		(state_r == OMC_STOP3) && IRQ_REQ |=> IRQ_STACK && (VEC_IRQ == $past(IRQ_ASYNC));
	endproperty
	a_stop3_vec: assert property (p_stop3_vec) else $error("stop3 wake took wrong vector"); // RULE_21

	c_wait_debug_pin: cover property ((state_r == OMC_WAIT) && bg_cmd ##1 CPU_SUSPEND);
	c_stop3_irq: cover property ((state_r == OMC_STOP3) && IRQ_REQ && IRQ_ASYNC ##1 VEC_IRQ);
	c_go: cover property (CPU_SUSPEND && cmd_ok && (CMD_CODE == CMD_GO) ##1 CPU_CLK_EN);
	c_stop2_ack: cover property (PPD_FLAG ##1 PPD_ACK ##1 !PPD_FLAG);

endmodule
